//--- logic/roi_bin.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module roi_bin #(
  parameter bit COLOUR_VARIANT = 1'b0
) (
  input  wire logic                CORE_CLK,      // 100 MHz pixel clock
  input  wire logic                NRST,          // synchronous reset, low
  input  wire logic                PSEL,          // APB select
  input  wire logic                PENABLE,       // APB access phase
  input  wire logic                PWRITE,        // APB write
  input  wire logic [7:0]          PADDR,         // APB byte address
  input  wire logic [31:0]         PWDATA,        // APB write data
  output logic [31:0]              PRDATA,        // APB read data
  output logic                     PREADY,        // APB ready
  output logic                     PSLVERR,       // APB error, unmapped
  input  wire roi_bin_pkg::pix_in_t  PIX_IN,      // sensor pixel beat
  input  wire logic                PIX_IN_VALID,  // sensor beat valid
  output logic                     PIX_IN_READY,  // block takes beat
  output roi_bin_pkg::pix_out_t    PIX_OUT,       // processed pixel beat
  output logic                     PIX_OUT_VALID, // output beat valid
  input  wire logic                PIX_OUT_READY, // link takes beat
  output logic                     READOUT_DONE   // last window row taken
);

  function automatic logic [1:0] factor_shift(input logic [2:0] f);
    return (f == roi_bin_pkg::FACTOR_FOUR) ? 2'h2 : ((f == roi_bin_pkg::FACTOR_TWO) ? 2'h1 : 2'h0);
  endfunction

  function automatic logic [15:0] rescale(input logic [15:0] v, input logic [1:0] o, input logic [1:0] n);
    logic [17:0] s;
    s = {2'h0, v} << o;
    return 16'(s >> n);
  endfunction

  logic [15:0] col_count, row_count, col_start, row_start;
  logic [2:0]  row_factor, col_factor;
  logic        row_method, col_method;
  logic [15:0] col, row, hacc;
  logic        first_pend, done;
  logic [1:0]  cnt;
  logic        wp, rp;
  roi_bin_pkg::pix_out_t bmem [2];
  logic [15:0] lmem [roi_bin_pkg::MEM_DEPTH];

  // Register access.
  wire         wr_en    = PSEL && PENABLE && PWRITE;
  wire         sel_cc   = PADDR == roi_bin_pkg::OFF_COL_COUNT;
  wire         sel_rc   = PADDR == roi_bin_pkg::OFF_ROW_COUNT;
  wire         sel_cs   = PADDR == roi_bin_pkg::OFF_COL_START;
  wire         sel_rs   = PADDR == roi_bin_pkg::OFF_ROW_START;
  wire         sel_rf   = PADDR == roi_bin_pkg::OFF_ROW_FACTOR;
  wire         sel_rm   = PADDR == roi_bin_pkg::OFF_ROW_METHOD;
  wire [2:0]   wr_f     = PWDATA[2:0];
  wire         f_legal  = (wr_f == roi_bin_pkg::FACTOR_ONE) || (wr_f == roi_bin_pkg::FACTOR_TWO)
                          || (wr_f == roi_bin_pkg::FACTOR_FOUR);
  // The colour variant refuses every factor write and stays at factor one, so it never combines.
  wire         f_write  = wr_en && sel_rf && f_legal && !COLOUR_VARIANT;
  wire [1:0]   sh       = factor_shift(row_factor);
  wire [1:0]   new_sh   = factor_shift(wr_f);
  wire [15:0]  col_lim  = roi_bin_pkg::SENSOR_COLS >> sh;
  wire [15:0]  row_lim  = roi_bin_pkg::SENSOR_ROWS >> sh;
  logic [31:0] rd_mux;
  logic        hit;

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    if (sel_cc) begin
      rd_mux = {16'h0000, col_count};
    end else if (sel_rc) begin
      rd_mux = {16'h0000, row_count};
    end else if (sel_cs) begin
      rd_mux = {16'h0000, col_start};
    end else if (sel_rs) begin
      rd_mux = {16'h0000, row_start};
    end else if (sel_rf) begin
      rd_mux = {29'h0, row_factor};
    end else if (sel_rm) begin
      rd_mux = {31'h0, row_method};
    end else if (PADDR == roi_bin_pkg::OFF_COL_FACTOR) begin
      rd_mux = {29'h0, col_factor};
    end else if (PADDR == roi_bin_pkg::OFF_COL_METHOD) begin
      rd_mux = {31'h0, col_method};
    end else if (PADDR == roi_bin_pkg::OFF_SENSOR_COLS) begin
      rd_mux = {16'h0000, roi_bin_pkg::SENSOR_COLS};
    end else if (PADDR == roi_bin_pkg::OFF_SENSOR_ROWS) begin
      rd_mux = {16'h0000, roi_bin_pkg::SENSOR_ROWS};
    end else if (PADDR == roi_bin_pkg::OFF_COL_LIMIT) begin
      rd_mux = {16'h0000, col_lim};
    end else if (PADDR == roi_bin_pkg::OFF_ROW_LIMIT) begin
      rd_mux = {16'h0000, row_lim};
    end else if (PADDR == roi_bin_pkg::OFF_STATUS) begin
      rd_mux = {29'h0, cnt, first_pend};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= rd_mux;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      col_count  <= roi_bin_pkg::SENSOR_COLS;
      row_count  <= roi_bin_pkg::SENSOR_ROWS;
      col_start  <= roi_bin_pkg::START_RESET;
      row_start  <= roi_bin_pkg::START_RESET;
      row_factor <= roi_bin_pkg::FACTOR_ONE;
      col_factor <= roi_bin_pkg::FACTOR_ONE;
      row_method <= roi_bin_pkg::METHOD_SUM;
      col_method <= roi_bin_pkg::METHOD_SUM;
    end else if (f_write) begin
      row_factor <= wr_f;
      col_factor <= wr_f;
      col_count  <= rescale(col_count, sh, new_sh);
      row_count  <= rescale(row_count, sh, new_sh);
      col_start  <= rescale(col_start, sh, new_sh);
      row_start  <= rescale(row_start, sh, new_sh);
    end else if (wr_en) begin
      if (sel_cc) begin
        col_count <= PWDATA[15:0];
      end
      if (sel_rc) begin
        row_count <= PWDATA[15:0];
      end
      if (sel_cs) begin
        col_start <= PWDATA[15:0];
      end
      if (sel_rs) begin
        row_start <= PWDATA[15:0];
      end
      if (sel_rm) begin
        row_method <= PWDATA[0];
        col_method <= PWDATA[0];
      end
    end
  end

  // Pixel path. Window values are held in output pixels and scaled to sensor pixels here.
  wire         in_fire  = PIX_IN_VALID && PIX_IN_READY;
  wire [15:0]  cur_col  = PIX_IN.sof ? 16'h0000 : col;
  wire [15:0]  cur_row  = PIX_IN.sof ? 16'h0000 : row;
  wire [15:0]  cs_s     = 16'(col_start << sh);
  wire [15:0]  rs_s     = 16'(row_start << sh);
  wire [15:0]  cw_s     = 16'(col_count << sh);
  wire [15:0]  rh_s     = 16'(row_count << sh);
  wire         in_win   = (cur_col >= cs_s) && (cur_col < 16'(cs_s + cw_s))
                          && (cur_row >= rs_s) && (cur_row < 16'(rs_s + rh_s));
  wire [15:0]  rc       = 16'(cur_col - cs_s);
  wire [15:0]  rr       = 16'(cur_row - rs_s);
  wire [1:0]   msk      = 2'((3'h1 << sh) - 3'h1);
  wire [1:0]   hp       = rc[1:0] & msk;
  wire [1:0]   vp       = rr[1:0] & msk;
  wire [11:0]  oc       = 12'(rc >> sh);
  wire [15:0]  hsum     = 16'((hp == 2'h0 ? 16'h0000 : hacc) + {4'h0, PIX_IN.data});
  wire [15:0]  vsum     = 16'((vp == 2'h0 ? 16'h0000 : lmem[oc]) + hsum);
  wire [15:0]  avg      = vsum >> {sh, 1'b0};
  wire         win_fire = in_fire && in_win;
  wire         col_last = rc == 16'(cw_s - 16'h0001);
  wire         row_last = rr == 16'(rh_s - 16'h0001);
  wire         push     = win_fire && (hp == msk) && (vp == msk);
  wire         pop      = PIX_OUT_VALID && PIX_OUT_READY;
  roi_bin_pkg::pix_out_t push_beat;

  assign push_beat.data = (row_method == roi_bin_pkg::METHOD_AVG) ? avg : vsum;
  assign push_beat.sof  = first_pend || PIX_IN.sof;
  assign push_beat.eol  = col_last;
  // Ready depends only on the fill level, so a full buffer stalls the sensor without losing a word.
  assign PIX_IN_READY   = cnt != roi_bin_pkg::BUF_FULL;
  assign PIX_OUT_VALID  = cnt != 2'h0;
  assign PIX_OUT        = bmem[rp];

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      col <= 16'h0000;
      row <= 16'h0000;
    end else if (in_fire) begin
      col <= PIX_IN.eol ? 16'h0000 : 16'(cur_col + 16'h0001);
      row <= PIX_IN.eol ? 16'(cur_row + 16'h0001) : cur_row;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      hacc <= 16'h0000;
    end else if (win_fire) begin
      hacc <= hsum;
    end
  end

  // The line store keeps partial column sums between rows; it is idle without combining.
  always_ff @(posedge CORE_CLK) begin
    if (win_fire && (hp == msk) && (sh != 2'h0)) begin
      lmem[oc] <= vsum;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      first_pend <= 1'b0;
    end else if (in_fire && PIX_IN.sof) begin
      first_pend <= !push;
    end else if (push) begin
      first_pend <= 1'b0;
    end
  end

  // Skipping rows after the window shortens readout; the last window row is read at most one column past the window's last column.
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      done <= 1'b0;
    end else begin
      done <= win_fire && col_last && row_last;
    end
  end
  assign READOUT_DONE = done;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      cnt     <= 2'h0;
      wp      <= 1'b0;
      rp      <= 1'b0;
      bmem[0] <= '0;
      bmem[1] <= '0;
    end else begin
      if (push) begin
        bmem[wp] <= push_beat;
        wp       <= !wp;
      end
      if (pop) begin
        rp <= !rp;
      end
      cnt <= 2'(cnt + {1'b0, push} - {1'b0, pop});
    end
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  AST_OUTSIDE_DROPPED: assert property (in_fire && !in_win |-> !push)
    else $error("pixel outside the window was emitted");
  AST_ORIGIN_ZERO: assert property (in_fire && PIX_IN.sof && col_start == 16'h0 && row_start == 16'h0
                                    |-> in_win)
    else $error("origin pixel not inside a window at zero offset");
  AST_RESET_SIZE: assert property ($rose(NRST) |-> col_count == col_lim && row_count == row_lim)
    else $error("window size not at its limit after reset");
  AST_DONE_PULSE: assert property (win_fire && col_last && row_last |=> READOUT_DONE ##1 !READOUT_DONE)
    else $error("readout end not a single pulse after last window pixel");
  AST_LIMIT_WRITE: assert property (wr_en && PADDR == roi_bin_pkg::OFF_COL_LIMIT && !f_write
                                    |=> $stable(col_lim))
    else $error("limit changed by a software write");
  AST_LIMIT_TWO: assert property (f_write && wr_f == roi_bin_pkg::FACTOR_TWO
                                  |=> col_lim == 16'h0f78 && row_lim == 16'h0bba)
    else $error("limits not halved after factor two");
  AST_RESCALE: assert property (f_write |=> row_count == rescale($past(row_count), $past(sh), sh))
    else $error("row count not rescaled on factor change");
  AST_PASS_THROUGH: assert property (push && sh == 2'h0 |-> push_beat.data == {4'h0, PIX_IN.data})
    else $error("uncombined pixel altered");
  AST_AVG_BOUND: assert property (push && row_method == roi_bin_pkg::METHOD_AVG
                                  |-> push_beat.data <= 16'h0fff)
    else $error("average exceeds pixel range");
  AST_FOLLOW: assert property (col_factor == row_factor && col_method == row_method)
    else $error("column settings do not follow row settings");
  AST_COLOUR: assert property (COLOUR_VARIANT |-> row_factor == roi_bin_pkg::FACTOR_ONE)
    else $error("colour variant combines pixels");
  AST_STALL: assert property (cnt == roi_bin_pkg::BUF_FULL && !pop |=> cnt == roi_bin_pkg::BUF_FULL
                              && !PIX_IN_READY)
    else $error("full buffer did not hold back the sensor");

  COV_FULL_STALL: cover property (cnt == roi_bin_pkg::BUF_FULL ##1 !PIX_IN_READY);
  COV_FOUR_AVG: cover property (push && sh == 2'h2 && row_method == roi_bin_pkg::METHOD_AVG);
  COV_DONE: cover property (READOUT_DONE);

endmodule

//--- inc/roi_bin_pkg.sv
// Overview of operation
// - Only pixels inside the programmed window leave; pixel values are unchanged at factor one only.
// - Window offsets count from sensor pixel zero; every size is in pixels.
// - Column and row counts reset to their limits; software writes size first.
// - Readout ends after the last window pixel; at most one later column of that row is read.
// - Sensor column and row counts are read-only; writes to them are ignored.
// - Column and row limits follow the current combine factor.
// - Factor changes rescale counts and offsets to the output resolution.
// - The row combine factor selects 1, 2 or 4 adjacent rows.
// - Sum method emits the total of the combined pixels.
// - Average method emits the total divided by the pixel count.
// - Column combine factor and method follow the row settings automatically.
// - The colour variant offers no combining; only monochrome combines pixels.
// - One pixel per clock is sustained so full-window frame rates hold.
package roi_bin_pkg;
  localparam logic [15:0] SENSOR_COLS     = 16'h1ef0;
  localparam logic [15:0] SENSOR_ROWS     = 16'h1774;
  localparam int          MEM_DEPTH       = 3960;
  localparam logic [7:0]  OFF_COL_COUNT   = 8'h00;
  localparam logic [7:0]  OFF_ROW_COUNT   = 8'h04;
  localparam logic [7:0]  OFF_COL_START   = 8'h08;
  localparam logic [7:0]  OFF_ROW_START   = 8'h0c;
  localparam logic [7:0]  OFF_ROW_FACTOR  = 8'h10;
  localparam logic [7:0]  OFF_ROW_METHOD  = 8'h14;
  localparam logic [7:0]  OFF_COL_FACTOR  = 8'h18;
  localparam logic [7:0]  OFF_COL_METHOD  = 8'h1c;
  localparam logic [7:0]  OFF_SENSOR_COLS = 8'h20;
  localparam logic [7:0]  OFF_SENSOR_ROWS = 8'h24;
  localparam logic [7:0]  OFF_COL_LIMIT   = 8'h28;
  localparam logic [7:0]  OFF_ROW_LIMIT   = 8'h2c;
  localparam logic [7:0]  OFF_STATUS      = 8'h30;
  localparam logic [2:0]  FACTOR_ONE      = 3'h1;
  localparam logic [2:0]  FACTOR_TWO      = 3'h2;
  localparam logic [2:0]  FACTOR_FOUR     = 3'h4;
  localparam logic        METHOD_SUM      = 1'b0;
  localparam logic        METHOD_AVG      = 1'b1;
  localparam logic [15:0] START_RESET     = 16'h0000;
  localparam logic [1:0]  BUF_FULL        = 2'h2;

  typedef struct packed {
    logic [11:0] data;
    logic        sof;
    logic        eol;
  } pix_in_t;

  typedef struct packed {
    logic [15:0] data;
    logic        sof;
    logic        eol;
  } pix_out_t;
endpackage

//--- verification/pixel_source.sv
`timescale 1ns/100ps
module pixel_source (
  input  wire logic            clk,   // pixel clock
  input  wire logic            nrst,  // synchronous reset, low
  input  wire logic            go,    // start one frame
  input  wire logic            ready, // block takes beat
  input  wire logic            done,  // readout may stop
  output roi_bin_pkg::pix_in_t pix,   // sensor beat
  output logic                 busy,  // frame running, also beat valid
  output int                   taken  // beats taken this frame
);
  logic [15:0] row;
  logic [15:0] col;
  logic [11:0] val;
  logic        last;
  assign val  = 12'(row * 13 + col * 3);
  assign last = (col == roi_bin_pkg::SENSOR_COLS - 16'h0001);
  // Outside a frame the data shows the inverse value, so a stale beat cannot pass for a fresh one.
  assign pix = busy ? {val, row == 16'h0000 && col == 16'h0000, last} : {~val, 2'b00};
  always_ff @(posedge clk) begin
    if (!nrst || go) begin
      busy  <= nrst;
      row   <= 16'h0000;
      col   <= 16'h0000;
      taken <= 0;
    end else if (busy) begin
      if (ready) begin
        taken <= taken + 1;
        col   <= last ? 16'h0000 : col + 16'h0001;
        row   <= last ? row + 16'h0001 : row;
      end
      if (done)
        busy <= 1'b0;
    end
  end
endmodule

//--- verification/image_roi_crop_and_binning_test.sv
`timescale 1ns/100ps
module image_roi_crop_and_binning_test;
  logic                  core_clk;
  logic                  nrst;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  roi_bin_pkg::pix_in_t  pix_in;
  logic                  pix_in_valid;
  logic                  pix_in_ready;
  roi_bin_pkg::pix_out_t pix_out;
  logic                  pix_out_valid;
  logic                  pix_out_ready = 1'b0;
  logic                  readout_done;
  logic                  go;
  int                    taken;
  logic [31:0]           seed = 32'h4b7157b8;
  int                    n_errors;
  int                    n_tests;
  int                    n_out;
  int                    fac;
  int                    shf;
  int                    cstart;
  int                    ocols;
  logic                  meth;
  logic [31:0]           rd;
  logic                  er;
  logic [31:0]           prdata_colour;
  logic [31:0]           rdc;

  roi_bin u_dut (.CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIX_IN(pix_in),
    .PIX_IN_VALID(pix_in_valid), .PIX_IN_READY(pix_in_ready), .PIX_OUT(pix_out),
    .PIX_OUT_VALID(pix_out_valid), .PIX_OUT_READY(pix_out_ready), .READOUT_DONE(readout_done));
  pixel_source u_src (.clk(core_clk), .nrst(nrst), .go(go), .ready(pix_in_ready), .done(readout_done),
    .pix(pix_in), .busy(pix_in_valid), .taken(taken));
  // The colour build shares the bus, so every factor write the mono build takes must bounce off it.
  roi_bin #(.COLOUR_VARIANT(1'b1)) u_colour (.CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata_colour), .PREADY(), .PSLVERR(),
    .PIX_IN(pix_in), .PIX_IN_VALID(pix_in_valid), .PIX_IN_READY(), .PIX_OUT(), .PIX_OUT_VALID(),
    .PIX_OUT_READY(pix_out_ready), .READOUT_DONE());

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [11:0] px(int r, int c);
    return 12'(r * 13 + c * 3);
  endfunction

  function automatic logic [15:0] exp_px(int oi, int oj);
    int sum;
    sum = 0;
    for (int dy = 0; dy < fac; dy++)
      for (int dx = 0; dx < fac; dx++)
        sum += px(oi * fac + dy, (cstart + oj) * fac + dx);
    return 16'(meth ? sum >> (2 * shf) : sum);
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    rdc = prdata_colour;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_regs(input int s, input logic m, input logic [15:0] cc, input logic [15:0] rc,
                            input logic [15:0] cs);
    logic [15:0] e [12];
    e = '{cc, rc, cs, 16'h0000, 16'(1 << s), 16'(m), 16'(1 << s), 16'(m), roi_bin_pkg::SENSOR_COLS,
          roi_bin_pkg::SENSOR_ROWS, roi_bin_pkg::SENSOR_COLS >> s, roi_bin_pkg::SENSOR_ROWS >> s};
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk($sformatf("register %h", i * 4), {16'h0000, e[i]}, rd);
      if (i == 4)
        chk("colour factor", 32'h1, rdc);
    end
  endtask

  task automatic run_frame(input int s, input logic m, input int cs, input int oc, input int orows);
    int k;
    int lo;
    shf    = s;
    fac    = 1 << s;
    // Readout stops at most one beat after the last window pixel, long before that sensor row ends.
    lo     = (orows * fac - 1) * int'(roi_bin_pkg::SENSOR_COLS) + (cs + oc) * fac;
    meth   = m;
    cstart = cs;
    ocols  = oc;
    n_out  = 0;
    @(posedge core_clk);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    k = 0;
    while ((pix_in_valid === 1'b1 || n_out < oc * orows) && k < 70000) begin
      @(posedge core_clk);
      k++;
    end
    chk("output count", oc * orows, n_out);
    chk("rows read", 1, 32'(taken >= lo && taken <= lo + 1));
    $display("frame test done, factor %0d", fac);
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // The sink stalls about a quarter of the time, so the two-entry buffer fills and refuses.
  always @(posedge core_clk) begin
    seed          <= lfsr(seed);
    pix_out_ready <= |seed[1:0];
    if (pix_out_valid === 1'b1 && pix_out_ready === 1'b1) begin
      chk("pixel", {exp_px(n_out / ocols, n_out % ocols), n_out == 0, n_out % ocols == ocols - 1},
          32'(pix_out));
      n_out++;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    $display("unexpected timeout of the run");
    close_out();
  end

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, go} = '0;
    n_errors = 0;
    n_tests  = 0;
    ocols    = 1;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    check_regs(0, 1'b0, roi_bin_pkg::SENSOR_COLS, roi_bin_pkg::SENSOR_ROWS, 16'h0000);
    apb(1'b0, 8'h34, 32'h0);
    chk("unmapped error", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, roi_bin_pkg::OFF_SENSOR_COLS, seed);
    apb(1'b1, roi_bin_pkg::OFF_COL_FACTOR, 32'h4);
    apb(1'b1, roi_bin_pkg::OFF_ROW_FACTOR, 32'h3);
    apb(1'b1, roi_bin_pkg::OFF_COL_COUNT, 32'h180);
    apb(1'b1, roi_bin_pkg::OFF_ROW_COUNT, 32'h4);
    apb(1'b1, roi_bin_pkg::OFF_COL_START, 32'h10);
    check_regs(0, 1'b0, 16'h0180, 16'h0004, 16'h0010);
    $display("register test done");
    run_frame(0, 1'b0, 16, 384, 4);
    apb(1'b1, roi_bin_pkg::OFF_ROW_FACTOR, 32'h2);
    apb(1'b1, roi_bin_pkg::OFF_ROW_METHOD, 32'h0);
    check_regs(1, 1'b0, 16'h00c0, 16'h0002, 16'h0008);
    run_frame(1, 1'b0, 8, 192, 2);
    apb(1'b1, roi_bin_pkg::OFF_ROW_FACTOR, 32'h4);
    apb(1'b1, roi_bin_pkg::OFF_ROW_METHOD, 32'h1);
    check_regs(2, 1'b1, 16'h0060, 16'h0001, 16'h0004);
    apb(1'b1, roi_bin_pkg::OFF_COL_START, 32'h0);
    run_frame(2, 1'b1, 0, 96, 1);
    close_out();
  end
endmodule
